/* File: tmon_top.sv */
`timescale 1ns/1ps
module tmon_top #(
  parameter logic [6:0] SLAVE_ADDR = tmon_pkg::SLAVE_ADDR,
  parameter int         NUM_CH     = tmon_pkg::NUM_CH,
  parameter int         RAW_W      = tmon_pkg::RAW_W
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_out,
  input  wire logic             sleep_request_n_in,
  input  wire logic [RAW_W-1:0] adc_data_in,
  input  wire logic             adc_valid_in,
  output logic                  adc_enable_out,
  output logic [2:0]            adc_channel_out,
  output logic                  busy_out,
  output logic                  alert_out,
  output logic                  alert_oe_out
);
  // All state in one record; bus slave fields first, then the sequencer
  typedef struct packed {
    tmon_pkg::tmon_phase_type  phase;
    logic [3:0]                bits;
    logic [7:0]                sh;
    logic                      rw;
    logic                      idx;
    logic [7:0]                ptr;
    logic                      sda_oe;
    logic                      scl_q;
    logic                      sda_q;
    logic [7:0]                cfg;
    logic [NUM_CH-1:0][7:0]    temp;
    logic [NUM_CH-1:0][7:0]    thi;
    logic [NUM_CH-1:0][7:0]    tlo;
    logic [NUM_CH-1:0][7:0]    stage;
    logic [NUM_CH-1:0]         alarm;
    logic                      busy;
    logic [2:0]                ch;
    logic                      start_req;
    logic                      adc_en;
    logic                      alert_oe;
  } tmon_state_type;

  function automatic tmon_state_type rst_state();
    tmon_state_type s;
    s       = '0;
    s.phase = tmon_pkg::PH_IDLE;
    s.scl_q = 1'b1;
    s.sda_q = 1'b1;
    s.cfg   = tmon_pkg::CFG_RST;
    for (int i = 0; i < NUM_CH; i++) begin
      s.thi[i] = tmon_pkg::THIGH_RST;
      s.tlo[i] = tmon_pkg::TLOW_RST;
    end
    return s;
  endfunction

  // Reset image built once; thresholds start at their power-up limits
  localparam tmon_state_type RST_STATE = rst_state();
  localparam logic [2:0]     LAST_CH   = 3'(NUM_CH - 1);

  // Synchronised pin views and per-channel helpers
  tmon_state_type    q;
  tmon_state_type    d;
  logic [2:0]        pins_s;
  logic              scl_s;
  logic              sda_s;
  logic              sleep_n_s;
  logic [7:0]        new_deg;
  logic [NUM_CH-1:0][7:0] cand;
  logic [NUM_CH-1:0] hit;

  // Bus and sleep pins cross into the clock domain before any logic looks at them
  // Reset value of one stands for an idle bus and an awake part
  tmon_sync #(
    .W (3)
  ) u_sync (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({sleep_request_n_in, sda_in, scl_in}),
    .rst_val_in (3'h7),
    .sync_out   (pins_s)
  );

  assign scl_s     = pins_s[0];
  assign sda_s     = pins_s[1];
  assign sleep_n_s = pins_s[2];

  tmon_round #(
    .RAW_W (RAW_W),
    .FRAC  (tmon_pkg::RAW_FRAC)
  ) u_round (
    .raw_in  (adc_data_in),
    .deg_out (new_deg)
  );

  // Candidate results with the final channel folded in, then limit checks
  // Using the incoming value lets the flags land with the results
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign cand[gi] = (3'(gi) == q.ch) ? new_deg : q.stage[gi];
      assign hit[gi]  = ($signed(cand[gi]) >= $signed(q.thi[gi])) ||
                        ($signed(cand[gi]) <= $signed(q.tlo[gi]));
    end
  endgenerate

  // Register read mux; unmapped commands read as zero
  // Pointer survives between transfers, which receive byte relies on
  function automatic logic [7:0] read_reg(tmon_state_type s);
    logic [2:0] off;
    off = s.ptr[2:0];
    if (s.ptr[7:3] == tmon_pkg::CMD_TEMP[7:3] && off <= LAST_CH) begin
      return s.temp[off];
    end else if (s.ptr == tmon_pkg::CMD_STATUS) begin
      return {s.busy, 7'(s.alarm)};
    end else if (s.ptr == tmon_pkg::CMD_CFG) begin
      return s.cfg;
    end else if (s.ptr[7:3] == tmon_pkg::CMD_THIGH[7:3] && off <= LAST_CH) begin
      return s.thi[off];
    end else if (s.ptr[7:3] == tmon_pkg::CMD_TLOW[7:3] && off <= LAST_CH) begin
      return s.tlo[off];
    end else begin
      return 8'h00;
    end
  endfunction

  // Whole block next state: bus slave first, then the conversion sequencer
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       standby;
    logic [7:0] rdata;
    logic [2:0] woff;
    scl_rise = scl_s & ~q.scl_q;
    scl_fall = ~scl_s & q.scl_q;
    start_c  = scl_s & q.scl_q & q.sda_q & ~sda_s;
    stop_c   = scl_s & q.scl_q & ~q.sda_q & sda_s;
    standby  = ~sleep_n_s | q.cfg[tmon_pkg::CFG_STOP_BIT];
    rdata    = read_reg(q);
    woff     = q.ptr[2:0];
    d        = q;
    d.scl_q  = scl_s;
    d.sda_q  = sda_s;

    // Pin edges show up three clocks late; the master must hold each
    // bus clock level for at least two clk_in periods or an edge is lost
    // Bus slave keeps running whatever the standby state
    if (start_c) begin
      d.phase  = tmon_pkg::PH_ADDR;
      d.bits   = 4'h0;
      d.idx    = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.phase  = tmon_pkg::PH_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.phase)
        tmon_pkg::PH_ADDR, tmon_pkg::PH_RX: begin
          // Eight rises gather a byte; the following fall decides the ack
          if (scl_rise) begin
            d.sh   = {q.sh[6:0], sda_s};
            d.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == 4'h8) begin
            d.bits = 4'h0;
            if (q.phase == tmon_pkg::PH_ADDR) begin
              if (q.sh[7:1] == SLAVE_ADDR) begin
                d.rw     = q.sh[0];
                d.sda_oe = 1'b1;
                d.phase  = tmon_pkg::PH_ACK;
              end else begin
                d.phase = tmon_pkg::PH_IDLE;
              end
            end else begin
              d.sda_oe = 1'b1;
              d.phase  = tmon_pkg::PH_ACK;
              if (!q.idx) begin
                // Command byte selects the register for later reads
                d.ptr = q.sh;
                d.idx = 1'b1;
                if (q.sh == tmon_pkg::CMD_ONESHOT) begin
                  d.start_req = 1'b1;
                end
              end else if (q.ptr == tmon_pkg::CMD_CFG) begin
                d.cfg = q.sh;
              end else if (q.ptr[7:3] == tmon_pkg::CMD_THIGH[7:3] && woff <= LAST_CH) begin
                d.thi[woff] = q.sh;
              end else if (q.ptr[7:3] == tmon_pkg::CMD_TLOW[7:3] && woff <= LAST_CH) begin
                d.tlo[woff] = q.sh;
              end
            end
          end
        end
        tmon_pkg::PH_ACK: begin
          // Ack slot ends on this fall; reads load their byte right away
          if (scl_fall) begin
            d.bits = 4'h0;
            if (q.rw) begin
              // Read byte and receive byte both return the selected register
              d.sh     = rdata;
              d.sda_oe = ~rdata[7];
              d.phase  = tmon_pkg::PH_TX;
              if (q.ptr == tmon_pkg::CMD_STATUS) begin
                d.alarm = '0;
              end
            end else begin
              d.sda_oe = 1'b0;
              d.phase  = tmon_pkg::PH_RX;
            end
          end
        end
        tmon_pkg::PH_TX: begin
          // Each bit changes on a fall so it is steady before the next rise
          if (scl_fall) begin
            if (q.bits == 4'h7) begin
              d.sda_oe = 1'b0;
              d.phase  = tmon_pkg::PH_TXACK;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
              d.bits   = q.bits + 4'h1;
            end
          end
        end
        tmon_pkg::PH_TXACK: begin
          // Master ack asks for another byte; nack ends the read
          if (scl_rise) begin
            d.phase = sda_s ? tmon_pkg::PH_IDLE : tmon_pkg::PH_ACK;
          end
        end
        default: begin
          d.phase = tmon_pkg::PH_IDLE;
        end
      endcase
    end

    // Sequencer; staging keeps half-done sweeps away from the results
    // Standby is tested first so a queued start cannot slip past it
    if (standby) begin
      d.busy      = 1'b0;
      d.ch        = 3'h0;
      d.start_req = 1'b0;
    end else if (!q.busy) begin
      if (q.start_req || q.cfg[tmon_pkg::CFG_AUTO_BIT]) begin
        d.busy      = 1'b1;
        d.ch        = 3'h0;
        d.start_req = 1'b0;
      end
    end else if (adc_valid_in) begin
      d.stage[q.ch] = new_deg;
      if (q.ch == LAST_CH) begin
        d.busy  = 1'b0;
        d.temp  = cand;
        d.alarm = d.alarm | hit;
      end else begin
        d.ch = q.ch + 3'h1;
      end
    end
    // Enable follows busy but drops the moment standby arrives
    d.adc_en   = d.busy & ~standby;
    d.alert_oe = |d.alarm;
  end

  // Single register stage for the whole record
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // Open-drain pins only ever pull low
  // Outputs are bare flop fields, so nothing combinational reaches a pin
  assign sda_out         = 1'b0;
  assign alert_out       = 1'b0;
  assign sda_oe_out      = q.sda_oe;
  assign adc_enable_out  = q.adc_en;
  assign adc_channel_out = q.ch;
  assign busy_out        = q.busy;
  assign alert_oe_out    = q.alert_oe;
endmodule

/* File: tmon_pkg.sv */
package tmon_pkg;
  // Channel count and front-end sample format
  localparam int          NUM_CH       = 5;
  localparam int          RAW_W        = 12;
  localparam int          RAW_FRAC     = 4;
  // Bus slave address (7 bits)
  localparam logic [6:0]  SLAVE_ADDR   = 7'h18;
  // Command byte map
  localparam logic [7:0]  CMD_TEMP     = 8'h00;
  localparam logic [7:0]  CMD_STATUS   = 8'h08;
  localparam logic [7:0]  CMD_CFG      = 8'h09;
  localparam logic [7:0]  CMD_ONESHOT  = 8'h0F;
  localparam logic [7:0]  CMD_THIGH    = 8'h10;
  localparam logic [7:0]  CMD_TLOW     = 8'h18;
  // Field positions
  localparam int          CFG_STOP_BIT = 7;
  localparam int          CFG_AUTO_BIT = 6;
  localparam int          STAT_BUSY    = 7;
  // Reset values
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [7:0]  THIGH_RST    = 8'h7F;
  localparam logic [7:0]  TLOW_RST     = 8'hC9;

  // Bus phases, Gray along idle-address-ack-receive-transmit
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h0,
    PH_ADDR  = 3'h1,
    PH_ACK   = 3'h3,
    PH_RX    = 3'h2,
    PH_TX    = 3'h6,
    PH_TXACK = 3'h7
  } tmon_phase_type;
endpackage

/* File: tmon_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser, one lane per bit
module tmon_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      // First stage feeds only the second
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q[i]   <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

/* File: tmon_round.sv */
`timescale 1ns/1ps
// Fixed-point reading to whole degrees, round to nearest, saturated
module tmon_round #(
  parameter int RAW_W = tmon_pkg::RAW_W,
  parameter int FRAC  = tmon_pkg::RAW_FRAC
) (
  input  wire logic signed [RAW_W-1:0] raw_in,
  output logic             [7:0]       deg_out
);
  logic signed [RAW_W:0] sum;
  logic signed [RAW_W:0] whole;
  localparam logic signed [RAW_W:0] HALF = (RAW_W+1)'(1) <<< (FRAC-1);
  localparam logic signed [RAW_W:0] MAXV = (RAW_W+1)'(127);
  localparam logic signed [RAW_W:0] MINV = -(RAW_W+1)'(128);

  // Half degree added before truncation; extra bit keeps the sum from wrapping
  always_comb begin
    sum   = {raw_in[RAW_W-1], raw_in} + HALF;
    whole = sum >>> FRAC;
    if (whole > MAXV) begin
      deg_out = 8'h7F;
    end else if (whole < MINV) begin
      deg_out = 8'h80;
    end else begin
      deg_out = whole[7:0];
    end
  end
endmodule

/* File: tmon_chk.sv */
`timescale 1ns/1ps
// Watches sweep sequencing, standby and the data pin
module tmon_chk #(
  parameter int NUM_CH = 5
) (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       scl_in,
  input wire logic       sleep_request_n_in,
  input wire logic       adc_valid_in,
  input wire logic       adc_enable_out,
  input wire logic [2:0] adc_channel_out,
  input wire logic       busy_out,
  input wire logic       sda_oe_out,
  input wire logic       alert_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Synchroniser plus state flop: five low samples leave no doubt
  a_standby_adc_off: assert property (
    !sleep_request_n_in [*5] |-> !adc_enable_out && !busy_out)
    else $error("converter active in standby");
  a_enable_in_sweep: assert property (
    adc_enable_out |-> busy_out || $past(busy_out))
    else $error("converter enabled outside a sweep");
  a_sweep_from_zero: assert property (
    $rose(busy_out) |-> ##[0:1] adc_channel_out == 3'h0)
    else $error("sweep did not start at channel 0");
  a_channel_held: assert property (
    busy_out && $past(busy_out) && !adc_valid_in |=> !busy_out || $stable(adc_channel_out))
    else $error("channel moved without a reading");
  a_sweep_end: assert property (
    adc_valid_in && adc_enable_out && adc_channel_out == 3'(NUM_CH - 1) |=> !busy_out)
    else $error("busy outlived the last channel");
  a_channel_range: assert property (
    adc_channel_out < 3'(NUM_CH))
    else $error("channel beyond the last one");
  // A change while the clock is high would read as a start or stop
  a_sda_still_high: assert property (
    scl_in [*5] |-> $stable(sda_oe_out))
    else $error("data changed while clock high");
  a_alert_after_sweep: assert property (
    $rose(alert_oe_out) |-> $past(busy_out) || $past(busy_out, 2) || $past(busy_out, 3))
    else $error("alert rose without a finished sweep");
  c_sweep_done: cover property (adc_valid_in && adc_channel_out == 3'(NUM_CH - 1));
  c_alert: cover property ($rose(alert_oe_out));
  c_ack: cover property ($rose(sda_oe_out));
endmodule

bind tmon_top tmon_chk #(.NUM_CH(NUM_CH)) u_tmon_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
  .sleep_request_n_in(sleep_request_n_in), .adc_valid_in(adc_valid_in),
  .adc_enable_out(adc_enable_out), .adc_channel_out(adc_channel_out),
  .busy_out(busy_out), .sda_oe_out(sda_oe_out), .alert_oe_out(alert_oe_out)
);

/* File: tmon_host.sv */
`timescale 1ns/1ps
// Bus master model; open drain, so it only ever pulls the data line low
module tmon_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // Idle bus until the first transfer
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // One bit of 8 clocks: data set mid-low, sampled late in the high phase
  task automatic bit_x(input logic b, output logic v);
    repeat (2) @(posedge clk_in);
    sda_low_out <= ~b;
    repeat (2) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    v = sda_in;
    @(posedge clk_in);
    scl_out <= 1'b0;
  endtask
  // Start (stop=0) or stop (stop=1); data is set up while the clock is low, then flips while it is high
  task automatic cond(input logic stop);
    repeat (2) @(posedge clk_in);
    sda_low_out <= stop;
    repeat (2) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_low_out <= ~stop;
    repeat (4) @(posedge clk_in);
    if (!stop) scl_out <= 1'b0;
  endtask
  // Byte MSB first, then the ninth bit released; reads always end with a nack
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Kind 0 send byte, 1 write byte, 2 read byte, 3 receive byte
  task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d,
                      input logic [1:0] kind, output logic [7:0] q, output logic ok);
    logic [7:0] t;
    logic       k;
    ok = 1'b1;
    q = 8'h00;
    cond(1'b0);
    if (kind != 2'h3) begin
      byte_x({a, 1'b0}, t, k);
      ok &= k;
      byte_x(cmd, t, k);
      ok &= k;
      if (kind == 2'h1) begin
        byte_x(d, t, k);
        ok &= k;
      end
      if (kind == 2'h2) cond(1'b0);  // Pointer set before reading
    end
    if (kind[1]) begin
      byte_x({a, 1'b1}, t, k);
      ok &= k;
      byte_x(8'hFF, q, k);
    end
    cond(1'b1);
  endtask
endmodule

/* File: temp_monitor_smbus_standby_tb.sv */
`timescale 1ns/1ps
module temp_monitor_smbus_standby_tb;
  logic        clk_in, rst_n_in, scl, host_low, sleep_n, sda_oe, adc_en, busy, alert_oe;
  logic        adc_valid = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic [11:0] raw [5];
  logic [7:0]  exp5 [5] = '{8'h19, 8'h01, 8'h00, 8'hFF, 8'h7F};
  logic [2:0]  adc_ch;
  logic [7:0]  q;
  logic        ok;
  int          mismatches = 0, checks_done = 0, cycles = 0, gap = 20, wait_n = 0;
  wire         sda = !(host_low || sda_oe);  // Pull-up wins unless a side pulls
  tmon_top u_tmon_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(sda_oe), .sleep_request_n_in(sleep_n), .adc_data_in(adc_data),
    .adc_valid_in(adc_valid), .adc_enable_out(adc_en), .adc_channel_out(adc_ch),
    .busy_out(busy), .alert_out(), .alert_oe_out(alert_oe));
  tmon_host u_tmon_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Front end: one reading per enabled gap, plus the run ceiling
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    adc_valid <= 1'b0;
    wait_n <= adc_en ? wait_n + 1 : 0;
    if (adc_en && wait_n >= gap) begin
      adc_valid <= 1'b1;
      adc_data <= raw[adc_ch];
      wait_n <= 0;
    end
    if (cycles == 60000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic [1:0] kind);
    u_tmon_host.xfer(tmon_pkg::SLAVE_ADDR, cmd, d, kind, q, ok);
    check({7'h0, ok}, 8'h01, "ack");
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    wr(cmd, 8'h00, 2'h2);
    check(q, exp, "read");
  endtask
  // Bounded wait; a sweep lasts well under 3000 cycles
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 3000 && busy !== lvl; n++) @(posedge clk_in);
    check({7'h0, busy}, {7'h0, lvl}, "busy");
  endtask
  task automatic t_reset();
    rd(tmon_pkg::CMD_THIGH + 8'h04, tmon_pkg::THIGH_RST);
    rd(tmon_pkg::CMD_TLOW, tmon_pkg::TLOW_RST);
    rd(tmon_pkg::CMD_CFG, tmon_pkg::CFG_RST);
    u_tmon_host.xfer(tmon_pkg::SLAVE_ADDR ^ 7'h01, tmon_pkg::CMD_CFG, 8'h00, 2'h2, q, ok);
    check({7'h0, ok}, 8'h00, "foreign address");
    $display("test reset done");
  endtask
  // Slow front end so an old result can be read while busy
  task automatic t_sweep();
    gap = 100;
    wr(tmon_pkg::CMD_ONESHOT, 8'h00, 2'h0);
    wait_busy(1'b1);
    rd(tmon_pkg::CMD_TEMP, 8'h00);
    wait_busy(1'b0);
    for (int c = 0; c < 5; c++) rd(tmon_pkg::CMD_TEMP + c[7:0], exp5[c]);
    wr(8'h00, 8'h00, 2'h3);
    check(q, 8'h7F, "receive byte");
    check({7'h0, alert_oe}, 8'h01, "alert");
    rd(tmon_pkg::CMD_STATUS, 8'h10);
    check({7'h0, alert_oe}, 8'h00, "alert cleared");
    $display("test sweep done");
  endtask
  task automatic t_sleep();
    sleep_n <= 1'b0;
    wr(tmon_pkg::CMD_ONESHOT, 8'h00, 2'h0);
    repeat (50) @(posedge clk_in);
    check({6'h0, busy, adc_en}, 8'h00, "standby converting");
    wr(tmon_pkg::CMD_THIGH, 8'h7E, 2'h1);
    rd(tmon_pkg::CMD_THIGH, 8'h7E);
    rd(tmon_pkg::CMD_TEMP, 8'h19);
    sleep_n <= 1'b1;
    repeat (50) @(posedge clk_in);
    check({7'h0, busy}, 8'h00, "dropped start");
    $display("test sleep done");
  endtask
  // Abort mid-sweep by config bit, then by pin; old results must survive
  task automatic t_abort();
    gap = 200;
    raw = '{12'h100, 12'h100, 12'h100, 12'h100, 12'h100};
    for (int m = 0; m < 2; m++) begin
      wr(tmon_pkg::CMD_ONESHOT, 8'h00, 2'h0);
      wait_busy(1'b1);
      repeat (150) @(posedge clk_in);
      if (m == 1) sleep_n <= 1'b0;
      else wr(tmon_pkg::CMD_CFG, 8'h80, 2'h1);
      repeat (10) @(posedge clk_in);
      check({7'h0, busy}, 8'h00, "abort");
      sleep_n <= 1'b1;
      wr(tmon_pkg::CMD_CFG, 8'h00, 2'h1);
      rd(tmon_pkg::CMD_TEMP, 8'h19);
      rd(tmon_pkg::CMD_TEMP + 8'h04, 8'h7F);
    end
    $display("test abort done");
  endtask
  task automatic t_auto();
    gap = 20;
    wr(tmon_pkg::CMD_CFG, 8'h40, 2'h1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    wr(tmon_pkg::CMD_CFG, 8'h00, 2'h1);
    for (int c = 0; c < 5; c++) rd(tmon_pkg::CMD_TEMP + c[7:0], 8'h10);
    $display("test auto done");
  endtask
  // Reading equal to a low limit raises the alarm; unmapped reads give zero
  task automatic t_low();
    wr(tmon_pkg::CMD_TLOW + 8'h01, 8'h10, 2'h1);
    rd(tmon_pkg::CMD_TLOW + 8'h01, 8'h10);
    wr(tmon_pkg::CMD_ONESHOT, 8'h00, 2'h0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check({7'h0, alert_oe}, 8'h01, "low alert");
    rd(tmon_pkg::CMD_STATUS, 8'h02);
    check({7'h0, alert_oe}, 8'h00, "low alert cleared");
    rd(8'h05, 8'h00);
    $display("test low done");
  endtask
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    rst_n_in = 1'b0;
    sleep_n = 1'b1;
    raw = '{12'h194, 12'h008, 12'hFF8, 12'hFF4, 12'h7FF};
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    t_reset();
    t_sweep();
    t_sleep();
    t_abort();
    t_auto();
    t_low();
    give_verdict();
  end
endmodule
